// [rtl/sync_param_pkg.sv]
// Purpose: constants for the subordinate-cycle synchronisation parameter bank
// Assumes: 32-bit register port, byte addresses, one word per register
// Notes:   input-side registers sit at the output-side offset plus 0x40
package sync_param_pkg;
  // ********************************************************
  // register word offsets (low six address bits; the interrupt pair as full eight-bit addresses)
  // ********************************************************
  localparam logic [5:0] OFS_SYNC_TYPE   = 6'h00;
  localparam logic [5:0] OFS_CYCLE_TIME  = 6'h04;
  localparam logic [5:0] OFS_SHIFT_TIME  = 6'h08;
  localparam logic [5:0] OFS_CAPS        = 6'h0C;
  localparam logic [5:0] OFS_MIN_CYCLE   = 6'h10;
  localparam logic [5:0] OFS_CALC_COPY   = 6'h14;
  localparam logic [5:0] OFS_MEASURE     = 6'h18;
  localparam logic [5:0] OFS_DELAY       = 6'h1C;
  localparam logic [5:0] OFS_PRIM_PERIOD = 6'h20;
  localparam logic [5:0] OFS_CNT_BASE    = 6'h24;
  localparam logic [5:0] OFS_SYNC_ERR    = 6'h34;
  localparam logic [7:0] OFS_IRQ_STATUS  = 8'h80;
  localparam logic [7:0] OFS_IRQ_MASK    = 8'h84;
  localparam int         ADDR_SIDE_BIT   = 6;
  // ********************************************************
  // fixed codes and field positions
  // ********************************************************
  localparam logic [15:0] OUT_SYNC_CODE  = 16'h0003;
  localparam logic [15:0] IN_SYNC_CODE   = 16'h0001;
  localparam logic [1:0]  CAP_SUBORD     = 2'b10;
  localparam logic [1:0]  CAP_NO_SHIFT   = 2'b00;
  localparam logic [1:0]  CAP_TMR_SHIFT  = 2'b01;
  localparam int          CAP_DC_LSB     = 2;
  localparam int          CAP_SHIFT_LSB  = 4;
  localparam int          MEAS_EN_BIT    = 0;
  // ********************************************************
  // counter and interrupt layout
  // ********************************************************
  localparam int          N_CNT          = 4;
  localparam int          CNT_TOO_SMALL  = 0;
  localparam int          CNT_MISSED     = 1;
  localparam int          CNT_SHORT      = 2;
  localparam int          CNT_TOGGLE     = 3;
  // ********************************************************
  // reset values and timing
  // ********************************************************
  localparam logic [31:0] RST_WORD       = 32'h0000_0000;
  localparam logic [15:0] RST_HALF       = 16'h0000;
  localparam logic [3:0]  RST_IRQ        = 4'h0;
  localparam int          CLK_PERIOD_NS  = 4;
endpackage

// [rtl/dc_subordinate_cycle_sync.sv]
// Purpose: synchronisation parameter bank and pulse timing for a slave
//          whose local cycle runs faster than the bus cycle
// Assumes: sync pulse pins are asynchronous; status inputs are on i_core_clk
// Notes:   input-side words mirror output-side words where shared
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module dc_subordinate_cycle_sync #(
  parameter bit          P_OUT_SHIFT   = 1'b1,          // output shift by timer offered
  parameter bit          P_IN_SHIFT    = 1'b1,          // input shift by timer offered
  parameter bit          P_VAR_CYCLE   = 1'b1,          // measure entry present
  parameter bit          P_ERR_CNT     = 1'b1,          // missed/short counters present
  parameter logic [31:0] P_MIN_CYCLE   = 32'h0000_0000, // least local cycle, ns
  parameter logic [31:0] P_CALC_COPY   = 32'h0000_0000, // calc and copy time, ns
  parameter logic [31:0] P_DELAY       = 32'h0000_0000  // hardware delay time, ns
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_srst,
  input  wire logic        i_clk_en,
  input  wire logic        i_primary_sync_pulse,
  input  wire logic        i_secondary_sync_pulse,
  input  wire logic [31:0] i_secondary_cycle_time,
  input  wire logic [31:0] i_primary_pulse_period,
  input  wire logic [31:0] i_in_shift_time,
  input  wire logic        i_sm_event,
  input  wire logic        i_app_busy,
  input  wire logic        i_toggle_fail,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  output logic             o_local_cycle_start,
  output logic             o_outputs_apply,
  output logic             o_inputs_latch,
  output logic             o_irq
);
  // ********************************************************
  // pin synchronisers
  // ********************************************************
  logic [1:0] pin_raw;                 // both pulse pins
  logic [1:0] sy1_q, sy2_q, sy3_q;     // three-stage chains
  logic [1:0] lvl_q, lvl_d;            // agreed level
  logic [1:0] rise;                    // rising edge of agreed level

  assign pin_raw = {i_secondary_sync_pulse, i_primary_sync_pulse};

  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++) begin : g_pin
      // next agreed level only when stages two and three match
      always_comb begin
        lvl_d[gp] = lvl_q[gp];
        if (sy2_q[gp] == sy3_q[gp]) begin
          lvl_d[gp] = sy3_q[gp];
        end
      end
      // register the chain and the agreed level
      always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
          sy1_q[gp] <= 1'b0;
          sy2_q[gp] <= 1'b0;
          sy3_q[gp] <= 1'b0;
          lvl_q[gp] <= 1'b0;
        end else if (i_clk_en) begin
          sy1_q[gp] <= pin_raw[gp];
          sy2_q[gp] <= sy1_q[gp];
          sy3_q[gp] <= sy2_q[gp];
          lvl_q[gp] <= lvl_d[gp];
        end
      end
      assign rise[gp] = lvl_d[gp] & ~lvl_q[gp];
    end
  endgenerate

  logic prim_edge;                     // primary pulse event
  logic sec_edge;                      // secondary pulse event
  assign prim_edge = rise[0];
  assign sec_edge  = rise[1];

  // ********************************************************
  // register port decode
  // ********************************************************
  logic       side_in;                 // input-side object addressed
  logic [5:0] word;                    // offset within object
  logic       bank_hit;                // address inside either object
  assign side_in  = i_addr[sync_param_pkg::ADDR_SIDE_BIT];
  assign word     = i_addr[5:0];
  assign bank_hit = (i_addr[7] == 1'b0);

  logic wr_out;                        // write to output-side object
  assign wr_out = i_wr & bank_hit & ~side_in;

  // ********************************************************
  // configuration registers
  // ********************************************************
  logic [31:0] cyc_q, cyc_d;           // secondary pulse interval, ns
  logic [31:0] shift_q, shift_d;       // output shift time, ns
  logic [15:0] meas_q, meas_d;         // measure control word
  logic [31:0] per_q, per_d;           // cycles since last secondary pulse
  logic [3:0]  mask_q, mask_d;         // interrupt mask

  // next values of the configuration group
  always_comb begin
    cyc_d   = cyc_q;
    shift_d = shift_q;
    meas_d  = meas_q;
    mask_d  = mask_q;
    per_d   = (per_q == 32'hFFFF_FFFF) ? per_q : per_q + 32'h0000_0001;
    if (sec_edge) begin
      per_d = 32'h0000_0001;
      // interval from measurement or from the controller pair
      if (P_VAR_CYCLE && meas_q[sync_param_pkg::MEAS_EN_BIT]) begin
        cyc_d = per_q * 32'(sync_param_pkg::CLK_PERIOD_NS);
      end else begin
        cyc_d = i_secondary_cycle_time;
      end
    end
    if (wr_out && word == sync_param_pkg::OFS_CYCLE_TIME) begin
      cyc_d = i_wdata; // application copy
    end
    if (wr_out && word == sync_param_pkg::OFS_SHIFT_TIME) begin
      shift_d = i_wdata;
    end
    // measure entry shared by both objects, absent without variable cycle
    if (P_VAR_CYCLE && i_wr && bank_hit && word == sync_param_pkg::OFS_MEASURE) begin
      meas_d = i_wdata[15:0];
    end
    if (i_wr && i_addr == sync_param_pkg::OFS_IRQ_MASK) begin
      mask_d = i_wdata[3:0];
    end
  end

  // register the configuration group
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      cyc_q   <= sync_param_pkg::RST_WORD;
      shift_q <= sync_param_pkg::RST_WORD;
      meas_q  <= sync_param_pkg::RST_HALF;
      per_q   <= sync_param_pkg::RST_WORD;
      mask_q  <= sync_param_pkg::RST_IRQ;
    end else if (i_clk_en) begin
      cyc_q   <= cyc_d;
      shift_q <= shift_d;
      meas_q  <= meas_d;
      per_q   <= per_d;
      mask_q  <= mask_d;
    end
  end

  // ********************************************************
  // shift timers for outputs (0) and inputs (1)
  // ********************************************************
  logic [31:0] sh_ns [2];              // shift time per side, ns
  logic [1:0]  sh_on;                  // shift by timer offered
  logic [31:0] tmr_q [2];              // remaining cycles
  logic [31:0] tmr_d [2];
  logic [1:0]  busy_q, busy_d;         // timer running
  logic [1:0]  fire;                   // apply or latch this cycle
  logic [1:0]  short_ev;               // pulse came while still shifting

  assign sh_ns[0] = shift_q;
  assign sh_ns[1] = i_in_shift_time;
  assign sh_on    = {P_IN_SHIFT, P_OUT_SHIFT};

  genvar gs;
  generate
    for (gs = 0; gs < 2; gs++) begin : g_shift
      logic [31:0] load;               // shift in cycles, rounded up
      assign load = (sh_ns[gs] + 32'(sync_param_pkg::CLK_PERIOD_NS - 1))
                    / 32'(sync_param_pkg::CLK_PERIOD_NS);
      // instant only moves by the shift timer after a secondary pulse
      always_comb begin
        tmr_d[gs]    = tmr_q[gs];
        busy_d[gs]   = busy_q[gs];
        fire[gs]     = 1'b0;
        short_ev[gs] = 1'b0;
        if (busy_q[gs]) begin
          if (tmr_q[gs] <= 32'h0000_0001) begin
            fire[gs]   = 1'b1;
            busy_d[gs] = 1'b0;
          end else begin
            tmr_d[gs] = tmr_q[gs] - 32'h0000_0001;
          end
        end
        if (sec_edge) begin
          // previous shift still open: too short, restart
          short_ev[gs] = busy_q[gs] & ~fire[gs];
          if (!sh_on[gs] || load == 32'h0000_0000) begin
            fire[gs]   = 1'b1;
            busy_d[gs] = 1'b0;
          end else begin
            tmr_d[gs]  = load;
            busy_d[gs] = 1'b1;
          end
        end
      end
      // register the timer
      always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
          tmr_q[gs]  <= sync_param_pkg::RST_WORD;
          busy_q[gs] <= 1'b0;
        end else if (i_clk_en) begin
          tmr_q[gs]  <= tmr_d[gs];
          busy_q[gs] <= busy_d[gs];
        end
      end
    end
  endgenerate

  // ********************************************************
  // error events and counters
  // ********************************************************
  // number of error counters, fixed by the status layout
  localparam int N = sync_param_pkg::N_CNT;
  logic        sm_seen_q, sm_seen_d;   // sync manager event since last pulse
  logic [N-1:0] ev;                    // one error event per counter
  logic [15:0]  cnt_q [N];             // error counters
  logic [15:0]  cnt_d [N];
  logic         err_q, err_d;          // sync error flag

  // local cycle too small: new primary pulse while application busy
  assign ev[sync_param_pkg::CNT_TOO_SMALL] = prim_edge & i_app_busy;
  assign ev[sync_param_pkg::CNT_MISSED]    = P_ERR_CNT & sec_edge
                                             & ~(sm_seen_q | i_sm_event);
  assign ev[sync_param_pkg::CNT_SHORT]     = P_ERR_CNT & (|short_ev);
  assign ev[sync_param_pkg::CNT_TOGGLE]    = i_toggle_fail;

  // sync manager tracking and error flag
  always_comb begin
    sm_seen_d = sm_seen_q | i_sm_event;
    err_d     = err_q;
    if (sec_edge) begin
      sm_seen_d = 1'b0;
      err_d     = 1'b0;
    end
    // flag present only with missed/short counters
    if (ev[sync_param_pkg::CNT_MISSED] || ev[sync_param_pkg::CNT_SHORT]) begin
      err_d = 1'b1;
    end
  end

  genvar gc;
  generate
    for (gc = 0; gc < N; gc++) begin : g_cnt
      // one step per event cycle
      always_comb begin
        cnt_d[gc] = cnt_q[gc];
        if (ev[gc]) begin
          cnt_d[gc] = cnt_q[gc] + 16'h0001;
        end
      end
      always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
          cnt_q[gc] <= sync_param_pkg::RST_HALF;
        end else if (i_clk_en) begin
          cnt_q[gc] <= cnt_d[gc];
        end
      end
    end
  endgenerate

  // register event tracking
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      sm_seen_q <= 1'b0;
      err_q     <= 1'b0;
    end else if (i_clk_en) begin
      sm_seen_q <= sm_seen_d;
      err_q     <= err_d;
    end
  end

  // ********************************************************
  // interrupt status
  // ********************************************************
  logic [3:0] st_q, st_d;              // sticky event bits
  logic       irq_d;                   // next interrupt level

  // write one to clear, a new event wins over the clear
  always_comb begin
    st_d = st_q;
    if (i_wr && i_addr == sync_param_pkg::OFS_IRQ_STATUS) begin
      st_d = st_q & ~i_wdata[3:0];
    end
    st_d  = st_d | ev;
    irq_d = |(st_d & mask_d);
  end

  // ********************************************************
  // read mux
  // ********************************************************
  logic [15:0] caps;                   // capability word of addressed side
  logic [31:0] rd_d;                   // next read data

  // read data for the addressed word, unmapped reads zero
  always_comb begin
    caps = 16'h0000;
    caps[sync_param_pkg::CAP_DC_LSB +: 2] = sync_param_pkg::CAP_SUBORD;
    if (side_in) begin
      caps[sync_param_pkg::CAP_SHIFT_LSB +: 2] = P_IN_SHIFT ?
        sync_param_pkg::CAP_TMR_SHIFT : sync_param_pkg::CAP_NO_SHIFT;
    end else begin
      caps[sync_param_pkg::CAP_SHIFT_LSB +: 2] = P_OUT_SHIFT ?
        sync_param_pkg::CAP_TMR_SHIFT : sync_param_pkg::CAP_NO_SHIFT;
    end
    rd_d = 32'h0000_0000;
    if (i_rd && bank_hit) begin
      case (word)
        sync_param_pkg::OFS_SYNC_TYPE: begin
          rd_d = side_in ? {16'h0000, sync_param_pkg::IN_SYNC_CODE}
                         : {16'h0000, sync_param_pkg::OUT_SYNC_CODE};
        end
        sync_param_pkg::OFS_CYCLE_TIME: begin
          rd_d = cyc_q; // both sides same
        end
        sync_param_pkg::OFS_SHIFT_TIME: begin
          rd_d = side_in ? i_in_shift_time : shift_q;
        end
        sync_param_pkg::OFS_CAPS: begin
          rd_d = {16'h0000, caps};
        end
        sync_param_pkg::OFS_MIN_CYCLE: begin
          rd_d = P_MIN_CYCLE;
        end
        sync_param_pkg::OFS_CALC_COPY: begin
          rd_d = P_CALC_COPY;
        end
        sync_param_pkg::OFS_MEASURE: begin
          rd_d = P_VAR_CYCLE ? {16'h0000, meas_q} : 32'h0000_0000;
        end
        sync_param_pkg::OFS_DELAY: begin
          rd_d = P_DELAY;
        end
        sync_param_pkg::OFS_PRIM_PERIOD: begin
          rd_d = i_primary_pulse_period;
        end
        sync_param_pkg::OFS_SYNC_ERR: begin
          rd_d = {31'h0000_0000, err_q & P_ERR_CNT};
        end
        default: begin
          // counters, one word each, shared by both sides
          if (word >= sync_param_pkg::OFS_CNT_BASE && word < sync_param_pkg::OFS_SYNC_ERR) begin
            rd_d = {16'h0000, cnt_q[word[3:2] - 2'd1]};
          end
        end
      endcase
    end else if (i_rd && i_addr == sync_param_pkg::OFS_IRQ_STATUS) begin
      rd_d = {28'h000_0000, st_q};
    end else if (i_rd && i_addr == sync_param_pkg::OFS_IRQ_MASK) begin
      rd_d = {28'h000_0000, mask_q};
    end
  end

  // ********************************************************
  // output registers
  // ********************************************************
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      st_q                <= sync_param_pkg::RST_IRQ;
      o_irq               <= 1'b0;
      o_rdata             <= sync_param_pkg::RST_WORD;
      o_local_cycle_start <= 1'b0;
      o_outputs_apply     <= 1'b0;
      o_inputs_latch      <= 1'b0;
    end else if (i_clk_en) begin
      st_q                <= st_d;
      o_irq               <= irq_d;
      o_rdata             <= rd_d;
      o_local_cycle_start <= prim_edge;
      o_outputs_apply     <= fire[0];
      o_inputs_latch      <= fire[1];
    end
  end
endmodule

// [bench/dc_sync_asserts.sv]
// Purpose: port assertions for the sync parameter bank
// Assumes: one clock domain, synchronous active-high reset
// Notes:   attached to every bank instance by the bind at the foot
`timescale 1ns/1ps
module dc_sync_asserts #(
  parameter bit P_OUT_SHIFT = 1'b1, // output shift by timer offered
  parameter bit P_IN_SHIFT  = 1'b1  // input shift by timer offered
) (
  input wire logic        i_core_clk,
  input wire logic        i_srst,
  input wire logic        i_clk_en,
  input wire logic        i_primary_sync_pulse,
  input wire logic [31:0] i_primary_pulse_period,
  input wire logic [7:0]  i_addr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic        o_local_cycle_start,
  input wire logic        o_outputs_apply,
  input wire logic        o_inputs_latch
);
  // ********
  // properties
  // ********
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_srst);
  // a read taken at one address
  sequence s_read(logic [7:0] a);
    i_rd && i_clk_en && i_addr == a;
  endsequence
  // the answer word in the following cycle
  sequence s_word(logic [31:0] w);
    ##1 o_rdata == w;
  endsequence
  AST_START_AFTER_PIN: assert property ($rose(i_primary_sync_pulse) && i_clk_en
    |-> ##[1:6] o_local_cycle_start) else $error("no local start after primary pin");
  AST_START_ONE: assert property (o_local_cycle_start && i_clk_en |=>
    !o_local_cycle_start) else $error("local start longer than one cycle");
  AST_APPLY_ONE: assert property (o_outputs_apply && i_clk_en |=>
    !o_outputs_apply) else $error("output apply longer than one cycle");
  AST_LATCH_ONE: assert property (o_inputs_latch && i_clk_en |=>
    !o_inputs_latch) else $error("input latch longer than one cycle");
  AST_RD_IDLE: assert property (!i_rd && i_clk_en |=> o_rdata == 32'h0000_0000)
    else $error("read data not zero without a read");
  AST_OUT_TYPE: assert property (s_read(8'h00) |-> s_word(32'h0000_0003))
    else $error("output sync type wrong");
  AST_IN_TYPE: assert property (s_read(8'h40) |-> s_word(32'h0000_0001))
    else $error("input sync type wrong");
  AST_OUT_CAPS: assert property (s_read(8'h0C) |=>
    o_rdata[5:2] == {1'b0, P_OUT_SHIFT, 2'b10}) else $error("output caps wrong");
  AST_IN_CAPS: assert property (s_read(8'h4C) |=>
    o_rdata[5:2] == {1'b0, P_IN_SHIFT, 2'b10}) else $error("input caps wrong");
  AST_PERIOD_MIRROR: assert property (s_read(8'h60) |=>
    o_rdata == $past(i_primary_pulse_period)) else $error("input period not mirrored");
endmodule
bind dc_subordinate_cycle_sync dc_sync_asserts #(
  .P_OUT_SHIFT(P_OUT_SHIFT), .P_IN_SHIFT(P_IN_SHIFT)
) i_dc_sync_asserts (
  .i_core_clk(i_core_clk), .i_srst(i_srst), .i_clk_en(i_clk_en),
  .i_primary_sync_pulse(i_primary_sync_pulse),
  .i_primary_pulse_period(i_primary_pulse_period), .i_addr(i_addr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_local_cycle_start(o_local_cycle_start),
  .o_outputs_apply(o_outputs_apply), .o_inputs_latch(o_inputs_latch)
);

// [bench/fieldbus_master_model.sv]
// Purpose: far-side model driving the sync pins and sync manager events
// Assumes: pins idle low between pulses
// Notes:   each level is held four cycles so the pin filter sees it
`timescale 1ns/1ps
module fieldbus_master_model (
  input  wire logic i_clk,
  output logic      o_primary_sync_pulse,
  output logic      o_secondary_sync_pulse,
  output logic      o_sm_event
);
  // ********
  // pin drivers
  // ********
  initial begin
    o_primary_sync_pulse = 1'b0;
    o_secondary_sync_pulse = 1'b0;
    o_sm_event = 1'b0;
  end
  // one sync pulse, primary or secondary
  task automatic pulse(input bit sec);
    @(posedge i_clk);
    if (sec) begin
      o_secondary_sync_pulse <= 1'b1;
    end else begin
      o_primary_sync_pulse <= 1'b1;
    end
    repeat (4) @(posedge i_clk);
    o_primary_sync_pulse <= 1'b0;
    o_secondary_sync_pulse <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask
  // one-cycle sync manager event
  task automatic sm_pulse;
    @(posedge i_clk) o_sm_event <= 1'b1;
    @(posedge i_clk) o_sm_event <= 1'b0;
  endtask
endmodule

// [bench/test_dc_subordinate_cycle_sync.sv]
// Purpose: self-checking bench for the sync parameter bank
// Assumes: 250 MHz clock, master model drives the sync pins
// Notes:   counter checks use deltas, so earlier pulses do not matter
`timescale 1ns/1ps
module test_dc_subordinate_cycle_sync;
  // ********
  // wiring
  // ********
  localparam logic [31:0] MIN_CT = 32'h0000_1F40; // least local cycle
  localparam logic [31:0] CALC   = 32'h0000_03E8; // calc and copy
  localparam logic [31:0] DLY    = 32'h0000_00C8; // delay time
  localparam logic [31:0] PER    = 32'h0000_C350; // primary period
  localparam logic [31:0] SEC_CT = 32'h0003_0D40; // secondary interval
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        clk_en = 1'b1;
  logic        app_busy = 1'b0;
  logic        toggle_fail = 1'b0;
  logic [31:0] in_shift = 32'h0000_0000;
  logic [31:0] sec_ct = SEC_CT;
  logic [31:0] per = PER;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic        start, apply, latch, irq, prim, sec, sm;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          n_start = 0;
  int          n_apply = 0;
  always #2 clk = ~clk;
  dc_subordinate_cycle_sync #(
    .P_MIN_CYCLE(MIN_CT), .P_CALC_COPY(CALC), .P_DELAY(DLY)
  ) i_dc_subordinate_cycle_sync (
    .i_core_clk(clk), .i_srst(srst), .i_clk_en(clk_en),
    .i_primary_sync_pulse(prim), .i_secondary_sync_pulse(sec),
    .i_secondary_cycle_time(sec_ct), .i_primary_pulse_period(per),
    .i_in_shift_time(in_shift), .i_sm_event(sm), .i_app_busy(app_busy),
    .i_toggle_fail(toggle_fail), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .o_local_cycle_start(start),
    .o_outputs_apply(apply), .o_inputs_latch(latch), .o_irq(irq)
  );
  fieldbus_master_model i_fieldbus_master_model (
    .i_clk(clk), .o_primary_sync_pulse(prim), .o_secondary_sync_pulse(sec),
    .o_sm_event(sm)
  );
  // tallies of local starts and output applies
  always @(posedge clk) begin
    if (start) n_start <= n_start + 1;
    if (apply) n_apply <= n_apply + 1;
  end
  // verdict and end of run
  task automatic summarize;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read word stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd_reg(a, d);
    check($sformatf("reg %h", a), exp, d);
  endtask
  // one sync pulse; cycles from pin rise to apply (or start) and to latch
  task automatic pulse_lat(input bit s, output int la, output int li);
    la = -1;
    li = -1;
    fork
      i_fieldbus_master_model.pulse(s);
      for (int n = 0; n < 40; n++) begin
        @(posedge clk);
        #1;
        if (la < 0 && (s ? apply : start)) la = n;
        if (li < 0 && latch) li = n;
      end
    join
    if (la < 0 || (s && li < 0)) begin
      $display("ERROR pulse answer expected yes seen no");
      n_mismatch++;
      summarize();
    end
  endtask
  // every word of both objects straight after reset
  task automatic t_reset_vals;
    logic [31:0] e;
    for (int k = 0; k < 32; k++) begin
      case (k % 16)
        0: e = (k > 15) ? 32'h0000_0001 : 32'h0000_0003;
        3: e = 32'h0000_0018;
        4: e = MIN_CT;
        5: e = CALC;
        7: e = DLY;
        8: e = PER;
        default: e = 32'h0000_0000;
      endcase
      rd_chk(8'(k * 4), e);
    end
    rd_chk(8'h88, 32'h0000_0000);
  endtask
  // cycle time copy-in, read-only mirrors, measure entry
  task automatic t_regs;
    wr_reg(8'h04, 32'h0001_2345);
    rd_chk(8'h04, 32'h0001_2345);
    wr_reg(8'h44, 32'h0000_0BAD);
    wr_reg(8'h40, 32'h0000_0007);
    rd_chk(8'h44, 32'h0001_2345);
    rd_chk(8'h40, 32'h0000_0001);
    wr_reg(8'h18, 32'h0000_0001);
    rd_chk(8'h58, 32'h0000_0001);
    wr_reg(8'h58, 32'h0000_0000);
    rd_chk(8'h18, 32'h0000_0000);
    @(posedge clk) per <= 32'h0000_4E20;
    rd_chk(8'h60, 32'h0000_4E20);
  endtask
  // local starts per bus cycle and shifted apply and latch
  task automatic t_pulses;
    int a0, l0, a1, l1, s0, p0;
    pulse_lat(1'b1, a0, l0);
    rd_chk(8'h04, SEC_CT);
    rd_chk(8'h44, SEC_CT);
    wr_reg(8'h08, 32'h0000_0028);
    @(posedge clk) in_shift <= 32'h0000_0014;
    rd_chk(8'h48, 32'h0000_0014);
    pulse_lat(1'b1, a1, l1);
    check("apply delay", 32'(a0 + 10), 32'(a1));
    check("latch delay", 32'(l0 + 5), 32'(l1));
    s0 = n_start;
    p0 = n_apply;
    repeat (3) i_fieldbus_master_model.pulse(1'b0);
    @(posedge clk) sec_ct <= 32'h0000_9C40;
    pulse_lat(1'b1, a1, l1);
    check("local starts", 32'(s0 + 3), 32'(n_start));
    check("applies", 32'(p0 + 1), 32'(n_apply));
    rd_chk(8'h04, 32'h0000_9C40);
  endtask
  // clock enable low blocks a write to the output shift time
  task automatic t_freeze;
    @(posedge clk) clk_en <= 1'b0;
    wr_reg(8'h08, 32'h0000_0BAD);
    @(posedge clk) clk_en <= 1'b1;
    rd_chk(8'h08, 32'h0000_0028);
  endtask
  // error counters, their mirrors, sync error and the interrupt
  task automatic t_errors;
    logic [31:0] b0, b1, b2, b3;
    int a, l;
    rd_reg(8'h24, b0);
    rd_reg(8'h28, b1);
    rd_reg(8'h2C, b2);
    rd_reg(8'h30, b3);
    @(posedge clk) app_busy <= 1'b1;
    i_fieldbus_master_model.pulse(1'b0);
    @(posedge clk) app_busy <= 1'b0;
    rd_chk(8'h24, b0 + 1);
    rd_chk(8'h64, b0 + 1);
    wr_reg(8'h18, 32'h0000_0001);
    i_fieldbus_master_model.sm_pulse();
    pulse_lat(1'b1, a, l);
    pulse_lat(1'b1, a, l);
    rd_chk(8'h04, 32'h0000_00A0);
    rd_chk(8'h28, b1 + 1);
    rd_chk(8'h68, b1 + 1);
    rd_chk(8'h34, 32'h0000_0001);
    rd_chk(8'h74, 32'h0000_0001);
    wr_reg(8'h08, 32'h0000_0190);
    i_fieldbus_master_model.sm_pulse();
    i_fieldbus_master_model.pulse(1'b1);
    i_fieldbus_master_model.sm_pulse();
    i_fieldbus_master_model.pulse(1'b1);
    repeat (110) @(posedge clk);
    rd_chk(8'h2C, b2 + 1);
    rd_chk(8'h6C, b2 + 1);
    @(posedge clk) toggle_fail <= 1'b1;
    @(posedge clk) toggle_fail <= 1'b0;
    rd_chk(8'h30, b3 + 1);
    rd_chk(8'h70, b3 + 1);
    rd_chk(8'h80, 32'h0000_000F);
    check("irq masked", 32'h0000_0000, 32'(irq));
    wr_reg(8'h84, 32'h0000_0002);
    repeat (2) @(posedge clk);
    #1 check("irq raised", 32'h0000_0001, 32'(irq));
    wr_reg(8'h80, 32'h0000_000F);
    repeat (2) @(posedge clk);
    #1 check("irq cleared", 32'h0000_0000, 32'(irq));
    rd_chk(8'h80, 32'h0000_0000);
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    t_reset_vals();
    t_regs();
    t_pulses();
    t_freeze();
    t_errors();
    summarize();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    $display("ERROR run end expected before 20000 cycles seen 20000");
    n_mismatch++;
    summarize();
  end
endmodule
